/* File: pcie_device_control_status_regs_tb.sv */
// Purpose: directed register and event tests of the control and status bank
// Assumes: 250 MHz aclk, bus tasks follow axi4-lite handshakes
// Notes: aux power scenario runs last since it survives the port reset
`timescale 1ns/1ps
module pcie_device_control_status_regs_tb;
    logic aclk, aresetn, aux_por_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic corr_err_evt, nonfatal_err_evt, fatal_err_evt, unsupp_req_evt, debug_sequential_tag, aux_power_present;
    logic [13:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire corr_err_report, nonfatal_err_report, fatal_err_report, unsupp_req_report;
    wire max_payload_256, ext_tag_range_255, aux_power_pm_en;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int fails = 0;
    int samples_checked = 0;
    int i;
    localparam logic [13:0] CTL = 14'h0120, STS = 14'h0128, IST = 14'h0200, IMK = 14'h0204;
    pdcs_regs dut (.*);
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task final_report;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task tmo;
        fails++;
        final_report;
    endtask
    task wr(input logic [13:0] a, input logic [15:0] d, input logic [1:0] er);
        int n;
        logic dn;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        dn = 1'b0;
        for (n = 0; n < 50 && !dn; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
                s_axi_bready <= 1'b0;
                dn = 1'b1;
            end
        end
        if (!dn) tmo;
    endtask
    task rd(input logic [13:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        logic dn;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        dn = 1'b0;
        for (n = 0; n < 50 && !dn; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                chk("rdata", e, s_axi_rdata);
                chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
                s_axi_rready <= 1'b0;
                dn = 1'b1;
            end
        end
        if (!dn) tmo;
    endtask
    // one-cycle event pulse, then the report pulses one edge later
    task ev(input logic [3:0] v, input logic [3:0] er);
        @(posedge aclk);
        {unsupp_req_evt, fatal_err_evt, nonfatal_err_evt, corr_err_evt} <= v;
        @(posedge aclk);
        {unsupp_req_evt, fatal_err_evt, nonfatal_err_evt, corr_err_evt} <= 4'h0;
        #1;
        chk("report", {28'h0, er}, {28'h0, unsupp_req_report, fatal_err_report, nonfatal_err_report, corr_err_report});
    endtask
    task rst_port;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    initial begin
        {aresetn, aux_por_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
        {corr_err_evt, nonfatal_err_evt, fatal_err_evt, unsupp_req_evt} = 4'h0;
        {debug_sequential_tag, aux_power_present} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 34'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        aux_por_n <= 1'b1;
        rd(CTL, 32'h0, 2'h0);
        rd(STS, 32'h0, 2'h0);
        wr(CTL, 16'hffff, 2'h0);
        rd(CTL, 32'h05ef, 2'h0);
        wr(STS, 16'hffff, 2'h0);
        rd(STS, 32'h0, 2'h0);
        for (i = 0; i < 8; i++) begin
            wr(CTL, 16'(i << 5), 2'h0);
            @(posedge aclk);
            #1 chk("max_payload_256", {31'h0, i == 1}, {31'h0, max_payload_256});
        end
        wr(CTL, 16'h0100, 2'h0);
        @(posedge aclk);
        #1 chk("ext_tag", 32'h0, {31'h0, ext_tag_range_255});
        @(posedge aclk);
        debug_sequential_tag <= 1'b1;
        repeat (2) @(posedge aclk);
        #1 chk("ext_tag", 32'h1, {31'h0, ext_tag_range_255});
        @(posedge aclk);
        debug_sequential_tag <= 1'b0;
        wr(CTL, 16'h0000, 2'h0);
        ev(4'hf, 4'h0);
        rd(STS, 32'h000f, 2'h0);
        wr(CTL, 16'h000f, 2'h0);
        for (i = 0; i < 4; i++) ev(4'(1 << i), 4'(1 << i));
        wr(STS, 16'h0005, 2'h0);
        rd(STS, 32'h000a, 2'h0);
        wr(STS, 16'h000a, 2'h0);
        rd(STS, 32'h0, 2'h0);
        rd(IST, 32'h000f, 2'h0);
        wr(IMK, 16'h0001, 2'h0);
        ev(4'h1, 4'h1);
        @(posedge aclk);
        #1 chk("irq", 32'h1, {31'h0, irq});
        rd(IST, 32'h0001, 2'h0);
        repeat (2) @(posedge aclk);
        #1 chk("irq", 32'h0, {31'h0, irq});
        wr(IMK, 16'h0000, 2'h0);
        ev(4'h1, 4'h1);
        repeat (2) @(posedge aclk);
        #1 chk("irq", 32'h0, {31'h0, irq});
        wr(14'h0300, 16'h00ff, 2'h2);
        rd(14'h0300, 32'h0, 2'h2);
        aux_power_present <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(STS, 32'h0011, 2'h0);
        wr(CTL, 16'h0400, 2'h0);
        rst_port;
        rd(CTL, 32'h0400, 2'h0);
        #1 chk("aux_power_pm_en", 32'h1, {31'h0, aux_power_pm_en});
        @(posedge aclk);
        aux_por_n <= 1'b0;
        @(posedge aclk);
        aux_por_n <= 1'b1;
        rd(CTL, 32'h0, 2'h0);
        wr(CTL, 16'h0400, 2'h0);
        aux_power_present <= 1'b0;
        repeat (3) @(posedge aclk);
        rst_port;
        rd(STS, 32'h0, 2'h0);
        rd(CTL, 32'h0, 2'h0);
        #1 chk("aux_power_pm_en", 32'h0, {31'h0, aux_power_pm_en});
        final_report;
    end
endmodule

/* File: pdcs_defines.vh */
// Purpose: constants for the device control and status register bank
// Assumes: axi4-lite, 32-bit data, one register per aligned word
// Notes: byte address of a register is four times its index
`ifndef PDCS_DEFINES_VH
`define PDCS_DEFINES_VH

// register indices and their byte addresses
`define PDCS_IDX_DEVICE_CONTROL 12'h048
`define PDCS_IDX_DEVICE_STATUS 12'h04a
`define PDCS_IDX_IRQ_STATUS 12'h080
`define PDCS_IDX_IRQ_MASK 12'h081
`define PDCS_ADDR_WIDTH 14
`define PDCS_ADDR_DEVICE_CONTROL 14'h0120
`define PDCS_ADDR_DEVICE_STATUS 14'h0128
`define PDCS_ADDR_IRQ_STATUS 14'h0200
`define PDCS_ADDR_IRQ_MASK 14'h0204

// decoded register selects
`define PDCS_SEL_NONE 3'h0
`define PDCS_SEL_CTL 3'h1
`define PDCS_SEL_STS 3'h2
`define PDCS_SEL_IRQ_STS 3'h3
`define PDCS_SEL_IRQ_MASK 3'h4

// device control field positions
`define PDCS_CTL_CORR_ERR_REPORT_EN 0
`define PDCS_CTL_NONFATAL_ERR_REPORT_EN 1
`define PDCS_CTL_FATAL_ERR_REPORT_EN 2
`define PDCS_CTL_UNSUPP_REQ_REPORT_EN 3
`define PDCS_CTL_RELAXED_ORDER_EN 4
`define PDCS_CTL_MAX_PAYLOAD_LO 5
`define PDCS_CTL_MAX_PAYLOAD_HI 7
`define PDCS_CTL_EXT_TAG_EN 8
`define PDCS_CTL_PHANTOM_FUNC_EN 9
`define PDCS_CTL_AUX_POWER_PM_EN 10
`define PDCS_CTL_NO_SNOOP_EN 11
`define PDCS_CTL_MAX_READ_REQ_LO 12
`define PDCS_CTL_MAX_READ_REQ_HI 14

// device status field positions
`define PDCS_STS_AUX_POWER_DETECTED 4
`define PDCS_STS_TXN_PENDING 5

// reset values and encodings
`define PDCS_RST_CTL_FIELDS 16'h0000
`define PDCS_RST_ERR_BITS 4'h0
`define PDCS_MPS_256 3'h1
`define PDCS_RESP_OKAY 2'h0
`define PDCS_RESP_SLVERR 2'h2

`endif

/* File: pdcs_regs.v */
// Purpose: device control and device status registers of one switch port
// Assumes: single 250 MHz clock aclk, synchronous active-low reset aresetn
// Notes: error event inputs are one-cycle pulses from logic on aclk
//
// Contract
// - correctable error report enable, bit 0, rw
// - non-fatal error report enable, bit 1, rw
// - fatal error report enable, bit 2, rw
// - unsupported request report enable, bit 3
// - relaxed ordering bit reads zero, read-only
// - payload size field 7:5, code 1 is 256
// - bit 8 picks tag range under debug tagging
// - phantom function enable hardwired zero
// - aux power enable bit 10 survives port reset while aux power is detected
// - no-snoop enable reads zero, read-only
// - read request size field reads zero
// - correctable error detected, write one clears
// - non-fatal error detected, write one clears
// - fatal error detected, write one clears
// - unsupported request detected, write one clears
// - detection logged whatever the report enables
// - aux power detected bit, read-only
// - transactions pending bit hardwired zero
`timescale 1ns/1ps
`include "pdcs_defines.vh"

module pdcs_regs (
    input wire aclk,
    input wire aresetn,
    input wire aux_por_n,
    input wire [`PDCS_ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`PDCS_ADDR_WIDTH-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire corr_err_evt,
    input wire nonfatal_err_evt,
    input wire fatal_err_evt,
    input wire unsupp_req_evt,
    input wire debug_sequential_tag,
    input wire aux_power_present,
    output wire corr_err_report,
    output wire nonfatal_err_report,
    output wire fatal_err_report,
    output wire unsupp_req_report,
    output wire max_payload_256,
    output wire ext_tag_range_255,
    output wire aux_power_pm_en,
    output wire irq
);

    function [2:0] pdcs_decode;
        input [`PDCS_ADDR_WIDTH-1:0] addr;
        begin
            case (addr)
                `PDCS_ADDR_DEVICE_CONTROL: pdcs_decode = `PDCS_SEL_CTL;
                `PDCS_ADDR_DEVICE_STATUS: pdcs_decode = `PDCS_SEL_STS;
                `PDCS_ADDR_IRQ_STATUS: pdcs_decode = `PDCS_SEL_IRQ_STS;
                `PDCS_ADDR_IRQ_MASK: pdcs_decode = `PDCS_SEL_IRQ_MASK;
                default: pdcs_decode = `PDCS_SEL_NONE;
            endcase
        end
    endfunction

    // write channel state
    reg awready_ff;
    reg wready_ff;
    reg aw_held_ff;
    reg w_held_ff;
    reg [`PDCS_ADDR_WIDTH-1:0] aw_addr_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    // read channel state
    reg arready_ff;
    reg rvalid_ff;
    reg [31:0] rdata_ff;
    reg [1:0] rresp_ff;

    // register contents
    reg [3:0] err_report_en_ff;
    reg [2:0] max_payload_size_ff;
    reg ext_tag_en_ff;
    reg aux_pm_en_ff;
    reg [3:0] err_detected_ff;
    reg [3:0] irq_status_ff;
    reg [3:0] irq_mask_ff;
    reg aux_sync1_ff;
    reg aux_sync2_ff;

    // user-side outputs
    reg [3:0] err_report_ff;
    reg max_payload_256_ff;
    reg ext_tag_range_255_ff;
    reg irq_ff;

    wire [3:0] err_evt;
    wire wr_fire;
    wire rd_fire;
    wire [2:0] wr_sel;
    wire [2:0] rd_sel;
    wire [3:0] w1c_err;
    wire [3:0] rd_clr_irq;
    wire [15:0] ctl_view;
    wire [15:0] sts_view;
    reg [31:0] nxt_rdata;
    reg [1:0] nxt_rresp;

    assign err_evt = {unsupp_req_evt, fatal_err_evt, nonfatal_err_evt, corr_err_evt};
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    assign rd_fire = s_axi_arvalid && arready_ff;
    assign wr_sel = pdcs_decode(aw_addr_ff);
    assign rd_sel = pdcs_decode(s_axi_araddr);

    // reads of the control word show hardwired zeros in the ro fields
    assign ctl_view = {1'b0,
                       3'h0,
                       1'b0,
                       aux_pm_en_ff,
                       1'b0,
                       ext_tag_en_ff,
                       max_payload_size_ff,
                       1'b0,
                       err_report_en_ff};
    assign sts_view = {10'h000,
                       1'b0,
                       aux_sync2_ff,
                       err_detected_ff};

    // write path: address and data may arrive in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= {`PDCS_ADDR_WIDTH{1'b0}};
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `PDCS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_ff) begin
                aw_addr_ff <= s_axi_awaddr;
                aw_held_ff <= 1'b1;
                awready_ff <= 1'b0;
            end
            if (s_axi_wvalid && wready_ff) begin
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
                w_held_ff <= 1'b1;
                wready_ff <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= (wr_sel == `PDCS_SEL_NONE) ? `PDCS_RESP_SLVERR : `PDCS_RESP_OKAY;
            end
            // one write outstanding: readies return only once the answer is taken
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // read path
    always @* begin
        nxt_rresp = `PDCS_RESP_OKAY;
        case (rd_sel)
            `PDCS_SEL_CTL: nxt_rdata = {16'h0000, ctl_view};
            `PDCS_SEL_STS: nxt_rdata = {16'h0000, sts_view};
            `PDCS_SEL_IRQ_STS: nxt_rdata = {28'h0000000, irq_status_ff};
            `PDCS_SEL_IRQ_MASK: nxt_rdata = {28'h0000000, irq_mask_ff};
            default: begin
                nxt_rdata = 32'h00000000;
                nxt_rresp = `PDCS_RESP_SLVERR;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `PDCS_RESP_OKAY;
        end else begin
            if (rd_fire) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rdata_ff <= nxt_rdata;
                rresp_ff <= nxt_rresp;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    // control register: ro and reserved bits have no storage at all
    always @(posedge aclk) begin
        if (!aresetn) begin
            err_report_en_ff <= `PDCS_RST_ERR_BITS;
            max_payload_size_ff <= 3'h0;
            ext_tag_en_ff <= 1'b0;
        end else if (wr_fire && wr_sel == `PDCS_SEL_CTL) begin
            if (w_strb_ff[0]) begin
                err_report_en_ff <= w_data_ff[3:0];
                max_payload_size_ff <= w_data_ff[`PDCS_CTL_MAX_PAYLOAD_HI:`PDCS_CTL_MAX_PAYLOAD_LO];
            end
            if (w_strb_ff[1]) begin
                ext_tag_en_ff <= w_data_ff[`PDCS_CTL_EXT_TAG_EN];
            end
        end
    end

    // aux power presence comes from a pin, so it is synchronised first
    always @(posedge aclk) begin
        if (!aux_por_n) begin
            aux_sync1_ff <= 1'b0;
            aux_sync2_ff <= 1'b0;
        end else begin
            aux_sync1_ff <= aux_power_present;
            aux_sync2_ff <= aux_sync1_ff;
        end
    end

    // sticky enable: only power-on, a port reset without aux power, or a write of zero to bit 10 clears it
    always @(posedge aclk) begin
        if (!aux_por_n) begin
            aux_pm_en_ff <= 1'b0;
        end else if (!aresetn) begin
            if (!aux_sync2_ff) begin
                aux_pm_en_ff <= 1'b0;
            end
        end else if (wr_fire && wr_sel == `PDCS_SEL_CTL && w_strb_ff[1]) begin
            aux_pm_en_ff <= w_data_ff[`PDCS_CTL_AUX_POWER_PM_EN];
        end
    end

    assign w1c_err = (wr_fire && wr_sel == `PDCS_SEL_STS && w_strb_ff[0]) ? w_data_ff[3:0] : 4'h0;
    assign rd_clr_irq = (rd_fire && rd_sel == `PDCS_SEL_IRQ_STS) ? 4'hf : 4'h0;

    // per error class: detected flag, interrupt flag and gated report pulse
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_err
            always @(posedge aclk) begin
                if (!aresetn) begin
                    err_detected_ff[gi] <= 1'b0;
                    irq_status_ff[gi] <= 1'b0;
                    err_report_ff[gi] <= 1'b0;
                end else begin
                    // a new event beats a clear in the same cycle
                    err_detected_ff[gi] <= (err_detected_ff[gi] & ~w1c_err[gi])
                                           | err_evt[gi];
                    irq_status_ff[gi] <= (irq_status_ff[gi] & ~rd_clr_irq[gi]) | err_evt[gi];
                    err_report_ff[gi] <= err_evt[gi] & err_report_en_ff[gi];
                end
            end
        end
    endgenerate

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_ff <= 4'h0;
        end else if (wr_fire && wr_sel == `PDCS_SEL_IRQ_MASK && w_strb_ff[0]) begin
            irq_mask_ff <= w_data_ff[3:0];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            max_payload_256_ff <= 1'b0;
            ext_tag_range_255_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            // reserved size codes fall back to 128 bytes
            max_payload_256_ff <= (max_payload_size_ff == `PDCS_MPS_256);
            ext_tag_range_255_ff <= debug_sequential_tag & ext_tag_en_ff;
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign corr_err_report = err_report_ff[0];
    assign nonfatal_err_report = err_report_ff[1];
    assign fatal_err_report = err_report_ff[2];
    assign unsupp_req_report = err_report_ff[3];
    assign max_payload_256 = max_payload_256_ff;
    assign ext_tag_range_255 = ext_tag_range_255_ff;
    assign aux_power_pm_en = aux_pm_en_ff;
    assign irq = irq_ff;

endmodule

/* File: pdcs_regs_chk.sv */
// Purpose: port-level checks for the device control and status bank
// Assumes: single clock aclk, synchronous active-low reset aresetn
// Notes: read address is remembered so read data can be judged per register
`timescale 1ns/1ps
module pdcs_regs_chk (
    input wire aclk,
    input wire aresetn,
    input wire [13:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_bvalid,
    input wire corr_err_evt,
    input wire nonfatal_err_evt,
    input wire fatal_err_evt,
    input wire unsupp_req_evt,
    input wire corr_err_report,
    input wire nonfatal_err_report,
    input wire fatal_err_report,
    input wire unsupp_req_report,
    input wire debug_sequential_tag,
    input wire ext_tag_range_255,
    input wire irq
);
    logic [13:0] ra_ff;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            ra_ff <= s_axi_araddr;
        end
    end
    a_corr_report: assert property (corr_err_report |-> $past(corr_err_evt)) else $error("stray corr report");
    a_nonfatal_report: assert property (nonfatal_err_report |-> $past(nonfatal_err_evt)) else $error("stray nf");
    a_fatal_report: assert property (fatal_err_report |-> $past(fatal_err_evt)) else $error("stray fatal report");
    a_unsupp_report: assert property (unsupp_req_report |-> $past(unsupp_req_evt)) else $error("stray ur");
    a_ext_tag_gate: assert property (ext_tag_range_255 |-> $past(debug_sequential_tag)) else $error("tag range");
    a_ctl_ro_zero: assert property (
        s_axi_rvalid && ra_ff == 14'h0120 |-> (s_axi_rdata & 32'hfffffa10) == 32'h0)
        else $error("control ro bits set");
    a_sts_ro_zero: assert property (
        s_axi_rvalid && ra_ff == 14'h0128 |-> (s_axi_rdata & 32'hffffffe0) == 32'h0)
        else $error("status ro bits set");
    a_rdata_hi_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0) else $error("upper half set");
    c_read: cover property (s_axi_rvalid && ra_ff == 14'h0128);
    c_write: cover property (s_axi_bvalid);
    c_irq: cover property ($rose(irq));
endmodule
bind pdcs_regs pdcs_regs_chk u_chk (.*);
